/* rtl/eag_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eag_regs.svh"

module eag_core #(
	parameter int LIN_WIDTH = `EAG_LIN_WIDTH
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_writedata_i,
	output var  logic [31:0] avs_readdata_o,
	output var  logic        avs_waitrequest_o,
	output var  logic [63:0] linear_addr_o,
	output var  logic        fault_gp_o,
	output var  logic        fault_stack_o
);

	eag_pkg::eag_state_type s;
	eag_pkg::eag_state_type next_s;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
					      input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [63:0] trunc(input logic [63:0] v, input eag_pkg::eag_size_type sz);
		logic [63:0] r;
		r = v;
		unique case (sz)
			eag_pkg::size_16: r = v & `EAG_MASK_16;
			eag_pkg::size_32: r = v & `EAG_MASK_32;
			default:          r = v;
		endcase
		return r;
	endfunction : trunc

	// Bits 63 down to the top implemented bit must all match it.
	function automatic logic canonical(input logic [63:0] a);
		logic ok;
		ok = 1'b1;
		for (int i = LIN_WIDTH; i < 64; i++) begin
			if (a[i] != a[LIN_WIDTH-1]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : canonical

	function automatic logic [2:0] seg_slot(input eag_pkg::eag_seg_type sg);
		logic [2:0] r;
		r = 3'h4;
		unique case (sg)
			eag_pkg::seg_code:    r = 3'h0;
			eag_pkg::seg_data:    r = 3'h1;
			eag_pkg::seg_extra:   r = 3'h2;
			eag_pkg::seg_stack:   r = 3'h3;
			eag_pkg::seg_aux_one: r = 3'h4;
			eag_pkg::seg_aux_two: r = 3'h5;
			default:              r = 3'h1;
		endcase
		return r;
	endfunction : seg_slot

	eag_pkg::eag_mode_type mode;
	eag_pkg::eag_seg_type  seg_ovr;
	eag_pkg::eag_seg_type  eff_seg;
	eag_pkg::eag_size_type asz;
	eag_pkg::eag_size_type osz;
	logic [63:0]           disp_x;
	logic [63:0]           base_x;
	logic [63:0]           index_x;
	logic [63:0]           ea;
	logic [63:0]           off;
	logic [63:0]           lin;
	logic [15:0]           log_sel;
	logic                  implied_stack;
	logic                  aux_used;
	logic                  bad_canon;
	logic [31:0]           rd;
	logic [2:0]            slot;
	logic                  go;
	logic                  acc_wr;

	always_comb begin
		mode    = eag_pkg::eag_mode_type'(s.ctrl[`EAG_CTRL_MODE_LSB +: 2]);
		seg_ovr = eag_pkg::seg_none;
		if (s.ctrl[`EAG_CTRL_SEGOVR_LSB +: 3] != 3'h7) begin
			seg_ovr = eag_pkg::eag_seg_type'(s.ctrl[`EAG_CTRL_SEGOVR_LSB +: 3]);
		end
		implied_stack = s.ctrl[`EAG_CTRL_STACK_OP] | s.ctrl[`EAG_CTRL_BASE_SPBP];

		// Sizes are taken fresh from the control word on every computation,
		// so an override applies to each computation until the control word is rewritten.
		asz = eag_pkg::size_16;
		osz = eag_pkg::size_16;
		unique case (mode)
			eag_pkg::mode_real_addr: begin
				asz = s.ctrl[`EAG_CTRL_ASZ_OVR] ? eag_pkg::size_32 : eag_pkg::size_16;
				osz = s.ctrl[`EAG_CTRL_OSZ_OVR] ? eag_pkg::size_32 : eag_pkg::size_16;
			end
			eag_pkg::mode_protected, eag_pkg::mode_compat: begin
				asz = (s.ctrl[`EAG_CTRL_CS_D32] ^ s.ctrl[`EAG_CTRL_ASZ_OVR]) ?
				      eag_pkg::size_32 : eag_pkg::size_16;
				osz = (s.ctrl[`EAG_CTRL_CS_D32] ^ s.ctrl[`EAG_CTRL_OSZ_OVR]) ?
				      eag_pkg::size_32 : eag_pkg::size_16;
			end
			eag_pkg::mode_long64: begin
				asz = s.ctrl[`EAG_CTRL_ASZ_OVR] ? eag_pkg::size_32 : eag_pkg::size_64;
				osz = s.ctrl[`EAG_CTRL_OSZ_OVR] ? eag_pkg::size_16 : eag_pkg::size_32;
			end
		endcase

		// Segment selection: in 64-bit mode the legacy overrides are dropped.
		eff_seg  = implied_stack ? eag_pkg::seg_stack : eag_pkg::seg_data;
		aux_used = 1'b0;
		if (mode == eag_pkg::mode_long64) begin
			if (seg_ovr == eag_pkg::seg_aux_one || seg_ovr == eag_pkg::seg_aux_two) begin
				eff_seg  = seg_ovr;
				aux_used = 1'b1;
			end
		end else if (seg_ovr != eag_pkg::seg_none) begin
			eff_seg = seg_ovr;
		end

		// Displacement is a signed 32-bit value except the wide move form.
		if (mode == eag_pkg::mode_long64 && s.ctrl[`EAG_CTRL_DISP64]) begin
			disp_x = s.disp;
		end else begin
			disp_x = {{32{s.disp[31]}}, s.disp[31:0]};
		end
		base_x  = s.ctrl[`EAG_CTRL_BASE_VLD] ? s.base : 64'h0000_0000_0000_0000;
		index_x = s.ctrl[`EAG_CTRL_INDEX_VLD] ?
			  (s.index << s.ctrl[`EAG_CTRL_SCALE_LSB +: 2]) : 64'h0000_0000_0000_0000;
		ea  = base_x + index_x + disp_x;
		off = trunc(ea, asz);

		slot    = seg_slot(eff_seg);
		log_sel = s.sel[slot];

		lin = off;
		unique case (mode)
			eag_pkg::mode_real_addr: begin
				lin = ({48'h0000_0000_0000, log_sel} << 4) + off;
				lin = lin & `EAG_MASK_REAL_LIN;
			end
			eag_pkg::mode_protected, eag_pkg::mode_compat: begin
				// The linear space stays at 4G; wider physical reach is paging's job.
				lin = {32'h0000_0000, s.segbase[31:0] + off[31:0]};
			end
			eag_pkg::mode_long64: begin
				lin = off + (aux_used ? s.segbase : 64'h0000_0000_0000_0000);
			end
		endcase
		bad_canon = (mode == eag_pkg::mode_long64) && !canonical(lin);

		// Bus read mux.
		rd = 32'h0000_0000;
		if (avs_address_i[7:5] == `EAG_BLK_GPR) begin
			rd = s.gpr[avs_address_i[4:2]];
		end else if (avs_address_i[7:5] == `EAG_BLK_SEG) begin
			if (avs_address_i[4:2] == `EAG_SEG_FLAGS_IDX) begin
				rd = s.flags;
			end else if (avs_address_i[4:2] < `EAG_SEG_FLAGS_IDX) begin
				rd = {16'h0000, s.sel[avs_address_i[4:2]]};
			end
		end else begin
			unique case (avs_address_i)
				`EAG_OFF_CTRL:       rd = s.ctrl;
				`EAG_OFF_BASE_LO:    rd = s.base[31:0];
				`EAG_OFF_BASE_HI:    rd = s.base[63:32];
				`EAG_OFF_INDEX_LO:   rd = s.index[31:0];
				`EAG_OFF_INDEX_HI:   rd = s.index[63:32];
				`EAG_OFF_DISP_LO:    rd = s.disp[31:0];
				`EAG_OFF_DISP_HI:    rd = s.disp[63:32];
				`EAG_OFF_SEGBASE_LO: rd = s.segbase[31:0];
				`EAG_OFF_SEGBASE_HI: rd = s.segbase[63:32];
				`EAG_OFF_LIN_LO:     rd = s.lin[31:0];
				`EAG_OFF_LIN_HI:     rd = s.lin[63:32];
				`EAG_OFF_STATUS:     rd = {24'h00_0000, s.osz, s.asz, 1'b0, s.fault_stack,
							   s.fault_gp, s.done};
				`EAG_OFF_IPTR_LO:    rd = s.instr_pointer_64[31:0];
				`EAG_OFF_IPTR_HI:    rd = s.instr_pointer_64[63:32];
				`EAG_OFF_IPNEW_LO:   rd = s.iptr_new[31:0];
				`EAG_OFF_IPNEW_HI:   rd = s.iptr_new[63:32];
				`EAG_OFF_OFFS_LO:    rd = s.offs[31:0];
				`EAG_OFF_OFFS_HI:    rd = s.offs[63:32];
				`EAG_OFF_LOGSEL:     rd = {16'h0000, s.log_sel};
				default:             rd = 32'h0000_0000;
			endcase
		end

		// Every access takes two cycles: request seen, then one answer cycle.
		// This costs throughput but keeps the read data registered.
		next_s          = s;
		next_s.wait_req = 1'b1;
		acc_wr          = 1'b0;
		go              = 1'b0;
		if ((avs_read_i || avs_write_i) && s.wait_req) begin
			next_s.wait_req = 1'b0;
			next_s.rdata    = avs_read_i ? rd : 32'h0000_0000;
		end
		if (avs_write_i && !s.wait_req) begin
			acc_wr = 1'b1;
		end

		if (acc_wr) begin
			if (avs_address_i[7:5] == `EAG_BLK_GPR) begin
				next_s.gpr[avs_address_i[4:2]] = merge(s.gpr[avs_address_i[4:2]],
								       avs_writedata_i, avs_byteenable_i);
			end else if (avs_address_i[7:5] == `EAG_BLK_SEG) begin
				if (avs_address_i[4:2] == `EAG_SEG_FLAGS_IDX) begin
					next_s.flags = merge(s.flags, avs_writedata_i, avs_byteenable_i);
				end else if (avs_address_i[4:2] < `EAG_SEG_FLAGS_IDX) begin
					next_s.sel[avs_address_i[4:2]] = 16'(merge(
						{16'h0000, s.sel[avs_address_i[4:2]]},
						avs_writedata_i, avs_byteenable_i));
				end
			end else begin
				unique case (avs_address_i)
					`EAG_OFF_CTRL:
						next_s.ctrl = merge(s.ctrl, avs_writedata_i, avs_byteenable_i);
					`EAG_OFF_BASE_LO:
						next_s.base[31:0] = merge(s.base[31:0], avs_writedata_i,
									 avs_byteenable_i);
					`EAG_OFF_BASE_HI:
						next_s.base[63:32] = merge(s.base[63:32], avs_writedata_i,
									  avs_byteenable_i);
					`EAG_OFF_INDEX_LO:
						next_s.index[31:0] = merge(s.index[31:0], avs_writedata_i,
									  avs_byteenable_i);
					`EAG_OFF_INDEX_HI:
						next_s.index[63:32] = merge(s.index[63:32], avs_writedata_i,
									   avs_byteenable_i);
					`EAG_OFF_DISP_LO:
						next_s.disp[31:0] = merge(s.disp[31:0], avs_writedata_i,
									 avs_byteenable_i);
					`EAG_OFF_DISP_HI:
						next_s.disp[63:32] = merge(s.disp[63:32], avs_writedata_i,
									  avs_byteenable_i);
					`EAG_OFF_SEGBASE_LO:
						next_s.segbase[31:0] = merge(s.segbase[31:0], avs_writedata_i,
									    avs_byteenable_i);
					`EAG_OFF_SEGBASE_HI:
						next_s.segbase[63:32] = merge(s.segbase[63:32], avs_writedata_i,
									     avs_byteenable_i);
					`EAG_OFF_IPNEW_LO:
						next_s.iptr_new[31:0] = merge(s.iptr_new[31:0], avs_writedata_i,
									     avs_byteenable_i);
					`EAG_OFF_IPNEW_HI:
						next_s.iptr_new[63:32] = merge(s.iptr_new[63:32], avs_writedata_i,
									      avs_byteenable_i);
					`EAG_OFF_GO:
						go = 1'b1;
					`EAG_OFF_IPCMD: begin
						unique case (avs_writedata_i[1:0])
							2'h0:
								next_s.instr_pointer_64[15:0] = s.iptr_new[15:0];
							2'h1:
								next_s.instr_pointer_64 = {32'h0000_0000, s.iptr_new[31:0]};
							default:
								next_s.instr_pointer_64 = s.iptr_new;
						endcase
					end
					default: begin
					end
				endcase
			end
		end

		// A computation samples the stored operands; operands written in the
		// same access as the trigger are impossible since each access is one word.
		if (go) begin
			next_s.lin         = lin;
			next_s.offs        = off;
			next_s.log_sel     = log_sel;
			next_s.asz         = asz;
			next_s.osz         = osz;
			next_s.done        = 1'b1;
			next_s.fault_gp    = bad_canon && !implied_stack;
			next_s.fault_stack = bad_canon && implied_stack;
			if (bad_canon && implied_stack && aux_used) begin
				next_s.fault_gp    = 1'b1;
				next_s.fault_stack = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s          <= '0;
			s.wait_req <= 1'b1;
			s.ctrl     <= `EAG_CTRL_RESET;
			s.instr_pointer_64 <= `EAG_IPTR_RESET;
			s.asz      <= eag_pkg::size_16;
			s.osz      <= eag_pkg::size_16;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata_o    = s.rdata;
	assign avs_waitrequest_o = s.wait_req;
	assign linear_addr_o     = s.lin;
	assign fault_gp_o        = s.fault_gp;
	assign fault_stack_o     = s.fault_stack;

endmodule : eag_core
`default_nettype wire

/* rtl/eag_regs.svh */
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH

// Register byte offsets on the Avalon-MM slave.
`define EAG_OFF_CTRL       8'h00
`define EAG_OFF_BASE_LO    8'h04
`define EAG_OFF_BASE_HI    8'h08
`define EAG_OFF_INDEX_LO   8'h0C
`define EAG_OFF_INDEX_HI   8'h10
`define EAG_OFF_DISP_LO    8'h14
`define EAG_OFF_DISP_HI    8'h18
`define EAG_OFF_SEGBASE_LO 8'h1C
`define EAG_OFF_SEGBASE_HI 8'h20
`define EAG_OFF_GO         8'h28
`define EAG_OFF_LIN_LO     8'h2C
`define EAG_OFF_LIN_HI     8'h30
`define EAG_OFF_STATUS     8'h34
`define EAG_OFF_IPTR_LO    8'h38
`define EAG_OFF_IPTR_HI    8'h3C
`define EAG_OFF_IPNEW_LO   8'h40
`define EAG_OFF_IPNEW_HI   8'h44
`define EAG_OFF_IPCMD      8'h48
`define EAG_OFF_OFFS_LO    8'h4C
`define EAG_OFF_OFFS_HI    8'h50
`define EAG_OFF_LOGSEL     8'h54
`define EAG_BLK_GPR        3'h4
`define EAG_BLK_SEG        3'h5
`define EAG_SEG_FLAGS_IDX  3'h6

// Control register fields.
`define EAG_CTRL_MODE_LSB   0
`define EAG_CTRL_CS_D32     2
`define EAG_CTRL_ASZ_OVR    3
`define EAG_CTRL_OSZ_OVR    4
`define EAG_CTRL_STACK_OP   5
`define EAG_CTRL_DISP64     6
`define EAG_CTRL_SEGOVR_LSB 7
`define EAG_CTRL_BASE_VLD   10
`define EAG_CTRL_INDEX_VLD  11
`define EAG_CTRL_SCALE_LSB  12
`define EAG_CTRL_BASE_SPBP  14

// Reset values and address masks.
`define EAG_CTRL_RESET    32'h0000_0000
`define EAG_IPTR_RESET    64'h0000_0000_0000_0000
`define EAG_MASK_16       64'h0000_0000_0000_FFFF
`define EAG_MASK_32       64'h0000_0000_FFFF_FFFF
`define EAG_MASK_REAL_LIN 64'h0000_0000_000F_FFFF
`define EAG_LIN_WIDTH     48

`endif

/* rtl/eag_pkg.sv */
`default_nettype none
package eag_pkg;

	typedef enum logic [1:0] {
		mode_real_addr,
		mode_protected,
		mode_compat,
		mode_long64
	} eag_mode_type;

	typedef enum logic [1:0] {
		size_16,
		size_32,
		size_64
	} eag_size_type;

	typedef enum logic [2:0] {
		seg_none,
		seg_aux_one,
		seg_aux_two,
		seg_code,
		seg_data,
		seg_extra,
		seg_stack
	} eag_seg_type;

	typedef struct packed {
		logic              wait_req;
		logic [31:0]       rdata;
		logic [31:0]       ctrl;
		logic [63:0]       base;
		logic [63:0]       index;
		logic [63:0]       disp;
		logic [63:0]       segbase;
		logic [7:0][31:0]  gpr;
		logic [5:0][15:0]  sel;
		logic [31:0]       flags;
		logic [63:0]       instr_pointer_64;
		logic [63:0]       iptr_new;
		logic [63:0]       lin;
		logic [63:0]       offs;
		logic [15:0]       log_sel;
		logic              fault_gp;
		logic              fault_stack;
		logic              done;
		eag_size_type      asz;
		eag_size_type      osz;
	} eag_state_type;

endpackage : eag_pkg
`default_nettype wire

/* dv/eag_core_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eag_regs.svh"
module eag_core_asserts #(
	parameter int LIN_WIDTH = `EAG_LIN_WIDTH
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic [63:0] linear_addr_o,
	input wire logic        fault_gp_o,
	input wire logic        fault_stack_o
);
	// Mode is shadowed from every control write whatever the byte enables; avs_writedata_i[1:0] is taken as is.
	logic [1:0]  mode;
	logic        go;
	logic        canon;
	logic [63:0] top_bits;
	assign go = avs_write_i && !avs_waitrequest_o && {avs_address_i[7:2], 2'h0} == `EAG_OFF_GO;
	assign top_bits = $signed(linear_addr_o) >>> (LIN_WIDTH - 1);
	assign canon = top_bits == '0 || top_bits == '1;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= 2'h0;
		end else if (avs_write_i && !avs_waitrequest_o && avs_address_i[7:2] == 6'h00) begin
			mode <= avs_writedata_i[1:0];
		end
	end
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ack;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	sequence s_done;
		$past(go) && !$past(rst_i);
	endsequence
	a_bus_answer: assert property (s_req |=> s_ack)
		else $error("bus answer not one cycle");
	a_write_rdata: assert property (avs_write_i && !avs_waitrequest_o |-> avs_readdata_o == '0)
		else $error("read data on write");
	a_result_on_go: assert property (!$past(rst_i) && $changed(linear_addr_o) |-> $past(go))
		else $error("result changed without start");
	a_fault_single: assert property (!(fault_gp_o && fault_stack_o))
		else $error("both faults raised");
	a_fault_long: assert property (s_done ##0 (fault_gp_o || fault_stack_o) |-> mode == 2'h3)
		else $error("fault outside long mode");
	a_canon_match: assert property (s_done ##0 mode == 2'h3 |->
		(fault_gp_o || fault_stack_o) == !canon) else $error("canonical check wrong");
	a_real_cap: assert property (s_done ##0 mode == 2'h0 |->
		linear_addr_o <= `EAG_MASK_REAL_LIN) else $error("real linear over 20 bits");
	a_prot_cap: assert property (s_done ##0 mode inside {2'h1, 2'h2} |->
		linear_addr_o <= `EAG_MASK_32) else $error("linear over 4G");
	a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
		avs_waitrequest_o && linear_addr_o == '0 && !fault_gp_o && !fault_stack_o)
		else $error("reset values wrong");
endmodule : eag_core_asserts
bind eag_core eag_core_asserts #(.LIN_WIDTH(LIN_WIDTH)) eag_core_asserts_inst (
	.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .linear_addr_o(linear_addr_o),
	.fault_gp_o(fault_gp_o), .fault_stack_o(fault_stack_o));
`default_nettype wire

/* dv/eag_master.sv */
`timescale 1ns/1ps
`default_nettype none
module eag_master (
	input  wire logic        clk_i,
	input  wire logic [31:0] readdata_i,
	input  wire logic        waitrequest_i,
	output var  logic [7:0]  address_o,
	output var  logic        read_o,
	output var  logic        write_o,
	output var  logic [3:0]  byteenable_o,
	output var  logic [31:0] writedata_o
);
	// Whole words only; byteenable_o stays at 4'hF for every access.
	initial begin
		address_o = 8'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		byteenable_o = 4'hF;
		writedata_o = 32'h0000_0000;
	end
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_i);
		address_o <= a;
		writedata_o <= d;
		read_o <= !wr;
		write_o <= wr;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		q = readdata_i;
		read_o <= 1'b0;
		write_o <= 1'b0;
	endtask : xfer
endmodule : eag_master
`default_nettype wire

/* dv/test_effective_address_generation.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eag_regs.svh"
module test_effective_address_generation;
	localparam int W = 40;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  adr;
	logic        rd_s;
	logic        wr_s;
	logic [3:0]  be;
	logic [31:0] wd;
	logic [31:0] rdat;
	logic        wreq;
	logic [63:0] lin;
	logic        f_gp;
	logic        f_st;
	int          failures = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	initial forever #50 clk_i = ~clk_i;
	eag_core #(.LIN_WIDTH(W)) eag_core_inst (.clk_i(clk_i), .rst_i(rst_i),
		.avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_byteenable_i(be),
		.avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.linear_addr_o(lin), .fault_gp_o(f_gp), .fault_stack_o(f_st));
	eag_master eag_master_inst (.clk_i(clk_i), .readdata_i(rdat), .waitrequest_i(wreq),
		.address_o(adr), .read_o(rd_s), .write_o(wr_s), .byteenable_o(be), .writedata_o(wd));
	task automatic end_of_test;
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	// The ceiling sits well above the few thousand cycles the sequence needs.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		eag_master_inst.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		eag_master_inst.xfer(1'b0, a, 32'h0000_0000, q);
	endtask : rd
	task automatic wr64(input logic [7:0] a, input logic [63:0] v);
		wr(a, v[31:0]);
		wr(8'(a + 8'h04), v[63:32]);
	endtask : wr64
	function automatic logic [63:0] exp_lin(input logic [31:0] c, input logic [63:0] b, x, d,
			sb, input logic [5:0][15:0] sl, output logic [6:0] st, output logic [63:0] off,
			output logic [15:0] ls);
		logic        lg;
		logic        aux;
		logic        stk;
		logic        bad;
		logic [1:0]  az;
		logic [1:0]  oz;
		logic [2:0]  ov;
		logic [2:0]  si;
		logic [63:0] l;
		logic [63:0] t;
		lg = c[1:0] == 2'h3;
		ov = c[9:7];
		aux = ov == 3'h1 || ov == 3'h2;
		stk = (c[5] || c[14]) && !aux;
		az = lg ? (c[3] ? 2'h1 : 2'h2) : {1'b0, (c[1:0] != 2'h0 && c[2]) ^ c[3]};
		oz = lg ? {1'b0, !c[4]} : {1'b0, (c[1:0] != 2'h0 && c[2]) ^ c[4]};
		off = (c[10] ? b : '0) + (c[11] ? x << c[13:12] : '0)
			+ (lg && c[6] ? d : {{32{d[31]}}, d[31:0]});
		off = az == 2'h2 ? off : off & (az == 2'h1 ? `EAG_MASK_32 : `EAG_MASK_16);
		si = ov == 3'h1 ? 3'h4 : ov == 3'h2 ? 3'h5 : !lg && ov inside {[3'h3:3'h6]} ? ov - 3'h3
			: (c[5] || c[14]) ? 3'h3 : 3'h1;
		ls = sl[si];
		if (c[1:0] == 2'h0) l = ((64'(sl[si]) << 4) + off) & `EAG_MASK_REAL_LIN;
		else if (!lg) l = (sb + off) & `EAG_MASK_32;
		else l = off + (aux ? sb : '0);
		t = $signed(l) >>> (W - 1);
		bad = lg && t != '0 && t != '1;
		st = {oz, az, bad && stk, bad && !stk, 1'b1};
		return l;
	endfunction : exp_lin
	initial begin
		logic [31:0]      q;
		logic [31:0]      c;
		logic [63:0]      b, x, d, sb, iptr, nw, off, l;
		logic [5:0][15:0] sl;
		logic [6:0]       st;
		logic [15:0]      ls;
		logic [1:0]       cl [4];
		int               k;
		k = $urandom(25);
		cl = '{2'h2, 2'h0, 2'h1, 2'h3};
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`EAG_OFF_CTRL, q);
		check(q, `EAG_CTRL_RESET);
		rd(8'h60, q);
		check(q, 32'h0000_0000);
		for (k = 0; k < 8; k++) begin
			c = $urandom;
			wr(8'(8'h80 + 4 * k), c);
			rd(8'(8'h80 + 4 * k), q);
			check(q, c);
		end
		wr(8'hB8, c);
		rd(8'hB8, q);
		check(q, c);
		iptr = `EAG_IPTR_RESET;
		for (k = 0; k < 4; k++) begin
			nw = {$urandom, $urandom};
			wr64(`EAG_OFF_IPNEW_LO, nw);
			wr(`EAG_OFF_IPCMD, 32'(cl[k]));
			iptr = cl[k][1] ? nw : cl[k][0] ? {32'h0000_0000, nw[31:0]} : {iptr[63:16], nw[15:0]};
			rd(`EAG_OFF_IPTR_LO, q);
			check(q, iptr[31:0]);
			rd(`EAG_OFF_IPTR_HI, q);
			check(q, iptr[63:32]);
		end
		for (k = 0; k < 80; k++) begin
			c = $urandom & 32'h0000_7FFF;
			b = {$urandom, $urandom};
			x = {$urandom, $urandom};
			d = {$urandom, $urandom};
			sb = {$urandom, $urandom};
			if (k[1:0] == 2'h3) begin
				// Land exactly on either side of both canonical edges.
				c[1:0] = 2'h3;
				c[3] = 1'b0;
				c[9:7] = 3'h0;
				c[10] = 1'b1;
				c[11] = 1'b0;
				d = '0;
				b = '0;
				b[W - 1] = 1'b1;
				b = (k[3] ? b : -b) - 64'(k[2]);
			end
			for (int j = 0; j < 6; j++) begin
				sl[j] = 16'($urandom);
				wr(8'(8'hA0 + 4 * j), {16'h0000, sl[j]});
			end
			wr(`EAG_OFF_CTRL, c);
			wr64(`EAG_OFF_BASE_LO, b);
			wr64(`EAG_OFF_INDEX_LO, x);
			wr64(`EAG_OFF_DISP_LO, d);
			wr64(`EAG_OFF_SEGBASE_LO, sb);
			wr(`EAG_OFF_GO, c);
			l = exp_lin(c, b, x, d, sb, sl, st, off, ls);
			wr(`EAG_OFF_LIN_LO, ~l[31:0]);
			rd(`EAG_OFF_LIN_LO, q);
			check(q, l[31:0]);
			rd(`EAG_OFF_STATUS, q);
			check({q[7:4], q[2:0]}, st);
			rd(`EAG_OFF_OFFS_LO, q);
			check(q, off[31:0]);
			rd(`EAG_OFF_LOGSEL, q);
			check(q, {16'h0000, ls});
			check(lin, l);
			check({f_st, f_gp}, st[2:1]);
		end
		end_of_test();
	end
endmodule : test_effective_address_generation
`default_nettype wire
